/* File: core/wtme_encoder.sv */
// Purpose: Packs watchpoint, print and bus analyzer hits into byte packets
// Assumes: One request per packet, sink drains one byte per ready cycle
// Notes:   Bus analyzer body is a raw five byte pass-through
//
// Behaviour
// [RL1] Header kind field, background or trigger code
// [RL2] All message contents little endian
// [RL3] Relative address in one or two bytes
// [RL4] Stall flag marks earlier stall on full FIFO
// [RL5] Header bit 12 selects full or relative PC
// [RL6] Header bits 15:13 depend on channel type
// [RL7] Optional timestamp byte counts ticks since reference
// [RL8] Address-space tag only when matching any space
// [RL9] Relative PC from last sent PC
// [RL10] Instruction-address channel header, codes and length
// [RL11] Operand-address channel codes and length
// [RL12] Store-size code in header bits 15:13
// [RL13] Payload length follows store size
// [RL14] Eight byte store puts low word high
// [RL15] Select bit picks operand address or upper data
// [RL16] Instruction-value channel shares operand-address layout
// [RL17] Branch message background, code, two absolute flags
// [RL18] Branch target then branch source addresses
// [RL19] Compact delayed branch reports delay slot address
// [RL20] Print message trigger kind, fixed fifteen bytes
// [RL21] Print message tag, full PC, 64-bit value
// [RL22] Bus analyzer origin, codes, discard flag
// [RL23] Bytes leave header first, fields LSB first
`timescale 1ns/1ns

module wtme_encoder
   import wtme_pkg::*;
(
   input  wire logic      clk,
   input  wire logic      rstn,
   input  wire wtme_req_t req,
   input  wire logic      req_valid,
   output logic           req_ready,
   input  wire logic      force_full,
   input  wire logic      cpu_stalled,
   input  wire logic      ba_discard,
   input  wire logic      timer_tick,
   input  wire logic      ref_sent,
   input  wire logic [31:0] ref_pc,
   output logic [7:0]     out_byte,
   output logic           out_valid,
   output logic           out_last,
   input  wire logic      out_ready
);

   // Relative form when it fits, else four byte absolute
   function automatic wtme_addr_t enc_addr(
      input logic [31:0] newv,
      input logic [31:0] refv,
      input logic        force_abs
   );
      wtme_addr_t  r;
      logic [31:0] off;
      // Out of range offsets fall back to absolute, never wrap
      off = newv - refv;
      r.full = 1'b0;
      r.n    = `WTME_LEN_REL1;
      r.val  = {24'h000000, 1'b0, off[6:0]};             // [RL3]
      if (force_abs ||
          $signed(off) < `WTME_REL2_MIN ||
          $signed(off) > `WTME_REL2_MAX) begin
         r.full = 1'b1;
         r.n    = `WTME_LEN_ABS;
         r.val  = newv;
      end else if ($signed(off) < `WTME_REL1_MIN ||
                   $signed(off) > `WTME_REL1_MAX) begin
         r.n   = `WTME_LEN_REL2;
         r.val = {16'h0000, off[14:7], 1'b1, off[6:0]};  // [RL3]
      end
      return r;
   endfunction

   // Append n low bytes of v at byte position pos
   function automatic logic [`WTME_BUF_W-1:0] put(
      input logic [`WTME_BUF_W-1:0] b,
      input logic [4:0]             pos,
      input logic [63:0]            v,
      input logic [4:0]             n
   );
      logic [63:0] mask;
      // Mask keeps stray high bits of v out of later fields
      mask = ~({64{1'b1}} << {n, 3'b000});
      return b | ({96'h0, v & mask} << {pos, 3'b000});    // [RL2] [RL23]
   endfunction

   // One byte fewer, shared by the count and the last flag
   function automatic logic [4:0] less_one(
      input logic [4:0] v
   );
      return v - `WTME_LEN_BYTE;
   endfunction

   // Buffer holds twenty bytes, enough for the longest message of sixteen
   wtme_state_t                  state;
   logic [`WTME_BUF_W-1:0]       buffer;
   logic [4:0]                   remain;
   logic [31:0]                  pc_ref;
   logic [7:0]                   ts_count;
   logic                         stall_seen;
   logic                         drop_seen;

   wire logic take = req_valid && req_ready;
   // Channel class follows the channel code ranges
   wire logic is_ba = req.origin_ba;
   wire logic is_ia = !is_ba && req.chan <= `WTME_CH_IA_LAST;
   wire logic is_oa = !is_ba && !is_ia && req.chan <= `WTME_CH_OA_LAST;
   wire logic is_iv = !is_ba && !is_ia && !is_oa &&
                      req.chan <= `WTME_CH_IV_LAST;               // [RL16]
   wire logic is_br  = !is_ba && req.chan == `WTME_CH_BR;
   wire logic is_fpf = !is_ba && req.chan == `WTME_CH_FPF;
   wire logic has_store = is_oa || is_iv;
   // Print and analyzer takes must not block a reference reload
   wire logic pc_moves  = !is_ba && !is_fpf;

   // Compact delayed branches report the delay slot
   wire logic [31:0] src_addr = req.compact_delayed ?
                                req.delay_slot : req.br_src;      // [RL19]

   // Hold modes send absolute so each message stands alone
   wire wtme_addr_t pc_enc  = enc_addr(req.pc, pc_ref, force_full); // [RL9]
   wire wtme_addr_t dst_enc = enc_addr(req.branch_target_field, pc_ref,
                                       force_full);               // [RL18]
   // Source is relative to the target just sent
   wire wtme_addr_t src_enc = enc_addr(src_addr, req.branch_target_field,
                                       force_full);               // [RL18]

   // Undefined size codes are sent as no store
   wire logic [2:0] st_code = req.store_code[2] ?
                              req.store_code : `WTME_ST_NONE;     // [RL12]
   wire logic [4:0] pl_len =
      (st_code == `WTME_ST_B1) ? `WTME_LEN_PL1 :
      (st_code == `WTME_ST_B2) ? `WTME_LEN_PL2 :
      (st_code == `WTME_ST_NONE) ? `WTME_LEN_PL0 :
      `WTME_LEN_PL4;                                             // [RL13]
   wire logic [63:0] payload = {req.store_data[31:0],            // [RL14]
                                req.payload_select_bit ?
                                req.op_addr :
                                req.store_data[63:32]};          // [RL15]

   wire logic ts_on   = req.ts_en && !is_fpf;                    // [RL7]
   wire logic asid_on = is_fpf ||
                        (!is_ba && !req.asid_match_en);          // [RL8] [RL21]

   wtme_hdr_t              hdr;
   logic [`WTME_BUF_W-1:0] next_buffer;
   logic [4:0]             next_len;
   logic [31:0]            next_pc_ref;

   always_comb begin
      hdr.kind   = req.trigger ? `WTME_KIND_TRIG : `WTME_KIND_BACK; // [RL1]
      hdr.origin = is_ba ? `WTME_ORIG_BA : `WTME_ORIG_WPC;          // [RL22]
      hdr.chan   = req.chan;                                        // [RL10]
      hdr.stall  = is_ba ? drop_seen : stall_seen;            // [RL4] [RL22]
      hdr.flag12 = pc_enc.full;                                     // [RL5]
      hdr.other  = `WTME_ST_NONE;                                   // [RL10]
      if (has_store) begin
         hdr.other = st_code;                                 // [RL6] [RL11]
      end
      if (is_br) begin
         hdr.kind   = `WTME_KIND_BACK;                              // [RL17]
         hdr.flag12 = dst_enc.full;                                 // [RL17]
         hdr.other  = {2'b00, src_enc.full};                        // [RL17]
      end
      if (is_fpf) begin
         hdr.kind   = `WTME_KIND_TRIG;                              // [RL20]
         hdr.flag12 = 1'b0;
         hdr.other  = `WTME_ST_NONE;                                // [RL20]
      end
      if (is_ba) begin
         hdr.flag12 = 1'b0;
         hdr.other  = `WTME_ST_NONE;
      end
      next_buffer = put('0, 5'h00, {48'h0, hdr}, `WTME_LEN_HDR);   // [RL23]
      next_len    = `WTME_LEN_HDR;
      next_pc_ref = pc_ref;
      if (ts_on) begin
         next_buffer = put(next_buffer, next_len, {56'h0, ts_count},
                           `WTME_LEN_BYTE);                         // [RL7]
         next_len = next_len + `WTME_LEN_BYTE;
      end
      if (asid_on) begin
         next_buffer = put(next_buffer, next_len, {56'h0, req.asid},
                           `WTME_LEN_BYTE);                         // [RL8]
         next_len = next_len + `WTME_LEN_BYTE;
      end
      if (is_ba) begin
         next_buffer = put(next_buffer, next_len, {24'h0, req.ba_body},
                           `WTME_LEN_BA_BODY);
         next_len = next_len + `WTME_LEN_BA_BODY;
      end else if (is_fpf) begin
         // Full PC, reference kept untouched
         next_buffer = put(next_buffer, next_len, {32'h0, req.pc},
                           `WTME_LEN_ABS);                          // [RL21]
         next_len = next_len + `WTME_LEN_ABS;
         next_buffer = put(next_buffer, next_len, req.print_payload,
                           `WTME_LEN_PRINT);                        // [RL21]
         next_len = next_len + `WTME_LEN_PRINT;
      end else if (is_br) begin
         next_buffer = put(next_buffer, next_len, {32'h0, dst_enc.val},
                           dst_enc.n);                              // [RL18]
         next_len = next_len + dst_enc.n;
         next_buffer = put(next_buffer, next_len, {32'h0, src_enc.val},
                           src_enc.n);                              // [RL18]
         next_len = next_len + src_enc.n;
         next_pc_ref = src_addr;
      end else begin
         next_buffer = put(next_buffer, next_len, {32'h0, pc_enc.val},
                           pc_enc.n);                               // [RL9]
         next_len = next_len + pc_enc.n;
         next_pc_ref = req.pc;                                      // [RL9]
         if (has_store) begin
            next_buffer = put(next_buffer, next_len, payload,
                              pl_len);                        // [RL13] [RL11]
            next_len = next_len + pl_len;
         end
      end
   end

   // Last byte frees the request side on the edge that takes it
   wire logic byte_done = out_valid && out_ready;
   wire logic last_done = byte_done && remain == `WTME_LEN_BYTE;

   // Set wins over the clear taken by a new header
   wire logic next_stall_seen = cpu_stalled ||
                                (stall_seen && !(take && !is_ba)); // [RL4]
   wire logic next_drop_seen  = ba_discard ||
                                (drop_seen && !(take && is_ba));   // [RL22]

   // Saturates rather than wrapping to a misleading small count
   wire logic [7:0] next_ts_count =
      ref_sent ? (timer_tick ? `WTME_TS_ONE : 8'h00) :
      (timer_tick && ts_count != `WTME_TS_MAX) ?
      ts_count + `WTME_TS_ONE : ts_count;                          // [RL7]

   always_ff @(posedge clk) begin
      if (!rstn) begin
         stall_seen <= 1'b0;
         drop_seen  <= 1'b0;
         ts_count   <= 8'h00;
         pc_ref     <= 32'h00000000;
      end else begin
         // Sticky flags survive until the message that reports them
         stall_seen <= next_stall_seen;
         drop_seen  <= next_drop_seen;
         ts_count   <= next_ts_count;
         if (take && pc_moves) begin
            pc_ref <= next_pc_ref;
         end else if (ref_sent) begin
            pc_ref <= ref_pc;
         end
      end
   end

   assign out_byte = buffer[7:0];

   always_ff @(posedge clk) begin
      if (!rstn) begin
         state     <= WTME_IDLE;
         buffer    <= '0;
         remain    <= 5'h00;
         req_ready <= 1'b0;
         out_valid <= 1'b0;
         out_last  <= 1'b0;
      end else begin
         case (state)
            WTME_IDLE: begin
               // Drops on the taking edge so a held request is not retaken
               req_ready <= !take;
               if (take) begin
                  state     <= WTME_SEND;
                  buffer    <= next_buffer;
                  remain    <= next_len;
                  out_valid <= 1'b1;
                  out_last  <= 1'b0;
               end
            end
            WTME_SEND: begin
               if (last_done) begin
                  state     <= WTME_IDLE;
                  out_valid <= 1'b0;
                  out_last  <= 1'b0;
                  req_ready <= 1'b1;
               end else if (byte_done) begin
                  buffer   <= buffer >> 8;                          // [RL23]
                  remain   <= less_one(remain);
                  out_last <= less_one(remain) == `WTME_LEN_BYTE;
               end
            end
            default: begin
               state <= WTME_IDLE;
            end
         endcase
      end
   end

endmodule

/* File: core/wtme_cfg.svh */
// Purpose: Constants for the watchpoint trace message encoder
// Assumes: Included by the encoder package file
// Notes:   Header bit positions live in the header struct
`ifndef WTME_CFG_SVH
`define WTME_CFG_SVH

`define WTME_KIND_BACK     3'h2
`define WTME_KIND_TRIG     3'h3
`define WTME_ORIG_WPC      3'h0
`define WTME_ORIG_BA       3'h1

`define WTME_CH_IA_LAST    5'h03
`define WTME_CH_OA_LAST    5'h05
`define WTME_CH_IV_LAST    5'h07
`define WTME_CH_BR         5'h08
`define WTME_CH_FPF        5'h09

`define WTME_ST_NONE       3'h0
`define WTME_ST_B1         3'h4
`define WTME_ST_B2         3'h5
`define WTME_ST_B4         3'h6
`define WTME_ST_B8         3'h7

`define WTME_LEN_HDR       5'h02
`define WTME_LEN_BYTE      5'h01
`define WTME_LEN_ABS       5'h04
`define WTME_LEN_REL1      5'h01
`define WTME_LEN_REL2      5'h02
`define WTME_LEN_PL0       5'h04
`define WTME_LEN_PL1       5'h05
`define WTME_LEN_PL2       5'h06
`define WTME_LEN_PL4       5'h08
`define WTME_LEN_PRINT     5'h08
`define WTME_LEN_BA_BODY   5'h05

`define WTME_REL1_MIN      (-32'sh40)
`define WTME_REL1_MAX      (32'sh3f)
`define WTME_REL2_MIN      (-32'sh4000)
`define WTME_REL2_MAX      (32'sh3fff)

`define WTME_TS_MAX        8'hff
`define WTME_TS_ONE        8'h01
`define WTME_BUF_W         160

`endif

/* File: core/wtme_pkg.sv */
// Purpose: Types shared by the trace message encoder
// Assumes: Constants come from wtme_cfg.svh
// Notes:   Header struct fixes every header bit position
`include "wtme_cfg.svh"

package wtme_pkg;

   typedef struct packed {
      logic [2:0] other;
      logic       flag12;
      logic       stall;
      logic [4:0] chan;
      logic [2:0] origin;
      logic [2:0] kind;
   } wtme_hdr_t;

   typedef struct packed {
      logic        full;
      logic [4:0]  n;
      logic [31:0] val;
   } wtme_addr_t;

   typedef struct packed {
      logic        trigger;
      logic        origin_ba;
      logic [4:0]  chan;
      logic        ts_en;
      logic        asid_match_en;
      logic [7:0]  asid;
      logic [31:0] pc;
      logic [31:0] branch_target_field;
      logic [31:0] br_src;
      logic [31:0] delay_slot;
      logic        compact_delayed;
      logic [2:0]  store_code;
      logic [63:0] store_data;
      logic [31:0] op_addr;
      logic        payload_select_bit;
      logic [63:0] print_payload;
      logic [39:0] ba_body;
   } wtme_req_t;

   typedef enum logic {
      WTME_IDLE,
      WTME_SEND
   } wtme_state_t;

endpackage

/* File: bench/wtme_props.sv */
// Purpose: Port assertions for the trace message encoder
// Assumes: Bound to wtme_encoder, one clock domain
// Notes:   Byte count restarts at every accepting edge
`timescale 1ns/1ns
module wtme_props
   import wtme_pkg::*;
(
   input wire logic        clk,
   input wire logic        rstn,
   input wire wtme_req_t   req,
   input wire logic        req_valid,
   input wire logic        req_ready,
   input wire logic        force_full,
   input wire logic        cpu_stalled,
   input wire logic        ba_discard,
   input wire logic        timer_tick,
   input wire logic        ref_sent,
   input wire logic [31:0] ref_pc,
   input wire logic [7:0]  out_byte,
   input wire logic        out_valid,
   input wire logic        out_last,
   input wire logic        out_ready
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   logic [4:0] nb;
   logic [4:0] ch;
   logic       ba;
   // No reset: only read after a take has loaded them
   always_ff @(posedge clk) begin
      if (req_valid && req_ready) begin
         nb <= 5'h00;
         ch <= req.chan;
         ba <= req.origin_ba;
      end else if (out_valid && out_ready)
         nb <= nb + 5'h01;
   end
   sequence s_take; req_valid && req_ready; endsequence
   sequence s_wp; req_valid && req_ready && !req.origin_ba; endsequence
   sequence s_end; out_valid && out_ready && out_last && !ba; endsequence

   a_take_answer: assert property (s_take |=> out_valid && !req_ready)
      else $error("no first byte after take");
   a_hold_byte: assert property (out_valid && !out_ready |=> $stable(out_byte))
      else $error("byte changed while stalled");
   a_end_free: assert property (out_valid && out_ready && out_last |=>
      !out_valid && req_ready)
      else $error("no release after last byte");
   a_kind_field: assert property (s_wp ##0 req.chan < 5'h08 |=>
      out_byte[2:0] == ($past(req.trigger) ? 3'h3 : 3'h2))
      else $error("wrong kind field");
   a_branch_hdr: assert property (s_wp ##0 req.chan == 5'h08 |=> out_byte == 8'h02)
      else $error("wrong branch header");
   a_print_hdr: assert property (s_wp ##0 req.chan == 5'h09 |=> out_byte == 8'h43)
      else $error("wrong print header");
   a_ba_origin: assert property (s_take ##0 req.origin_ba |=> out_byte[5:3] == 3'h1)
      else $error("wrong analyzer origin");
   a_print_len: assert property (s_end ##0 ch == 5'h09 |-> nb == 5'h0e)
      else $error("print message not fifteen bytes");
   a_ia_len: assert property (s_end ##0 ch < 5'h04 |-> nb inside {[2:7]})
      else $error("address message length out of range");
   a_oa_len: assert property (s_end ##0 ch inside {[4:7]} |-> nb inside {[6:15]})
      else $error("store message length out of range");
endmodule

bind wtme_encoder wtme_props props_u (.clk, .rstn, .req, .req_valid,
   .req_ready, .force_full, .cpu_stalled, .ba_discard, .timer_tick,
   .ref_sent, .ref_pc, .out_byte, .out_valid, .out_last, .out_ready);

/* File: bench/wtme_sink.sv */
// Purpose: Byte sink standing in for the debug FIFO
// Assumes: Fed by the encoder byte stream
// Notes:   Slow mode stalls every other cycle
`timescale 1ns/1ns
module wtme_sink (
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic       slow,
   input  wire logic [7:0] out_byte,
   input  wire logic       out_valid,
   input  wire logic       out_last,
   output logic            out_ready
);
   logic [7:0] q[$];
   int         n_msg = 0;
   logic       ph = 1'b0;
   initial out_ready = 1'b0;
   // Ready moves just after the edge, never on it
   always @(posedge clk) begin
      if (out_valid && out_ready) begin
         q.push_back(out_byte);
         if (out_last)
            n_msg++;
      end
      ph = !ph;
      out_ready <= #1 rstn && (!slow || ph);
   end
endmodule

/* File: bench/wtme_encoder_tb.sv */
// Purpose: Directed scenarios for the trace message encoder
// Assumes: wtme_sink drains bytes, slow mode stalls it
// Notes:   Expected bytes are worked out by hand per scenario
`timescale 1ns/1ns
module wtme_encoder_tb
   import wtme_pkg::*;
;
   logic        clk;
   logic        rstn = 1'b0;
   logic        req_valid = 1'b0;
   logic        force_full = 1'b0;
   logic        slow = 1'b0;
   logic [3:0]  sidev = 4'h0;
   logic [31:0] ref_pc = 32'h0000_1000;
   wtme_req_t   req = '0;
   wtme_req_t   r;
   wire         cpu_stalled, ba_discard, timer_tick, ref_sent;
   wire         req_ready, out_valid, out_last, out_ready;
   wire [7:0]   out_byte;
   int          errors = 0;
   int          n_tests = 0;

   assign {cpu_stalled, ba_discard, timer_tick, ref_sent} = sidev;
   initial begin
      clk = 1'b0;
      forever #50 clk = !clk;
   end
   wtme_encoder dut_u (.clk, .rstn, .req, .req_valid, .req_ready, .force_full,
      .cpu_stalled, .ba_discard, .timer_tick, .ref_sent, .ref_pc, .out_byte,
      .out_valid, .out_last, .out_ready);
   wtme_sink snk_u (.clk, .rstn, .slow, .out_byte, .out_valid, .out_last,
      .out_ready);

   task automatic final_report();
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] e, input logic [7:0] s);
      n_tests++;
      if (s !== e) begin
         errors++;
         $display("BAD %s exp %h got %h", what, e, s);
      end
   endtask
   task automatic side(input logic [3:0] v);
      sidev = v;
      @(posedge clk) #1;
   endtask
   task automatic clr();
      r = '0;
      r.asid_match_en = 1'b1;
   endtask
   // Hands r over once, waits for the whole message, compares every byte
   task automatic send(input logic [7:0] e[]);
      int k;
      int m0;
      m0 = snk_u.n_msg;
      snk_u.q.delete();
      for (k = 0; k < 50 && req_ready !== 1'b1; k++)
         @(posedge clk) #1;
      chk("ready", 8'h01, {7'h00, req_ready});
      if (req_ready !== 1'b1)
         final_report();
      req = r;
      req_valid = 1'b1;
      @(posedge clk) #1;
      req_valid = 1'b0;
      for (k = 0; k < 300 && snk_u.n_msg == m0; k++)
         @(posedge clk) #1;
      chk("message count", 8'(m0 + 1), 8'(snk_u.n_msg));
      if (snk_u.n_msg == m0)
         final_report();
      chk("length", 8'(e.size()), 8'(snk_u.q.size()));
      foreach (e[i])
         chk($sformatf("byte %0d", i), e[i], snk_u.q[i]);
   endtask

   task automatic t_ia_rel();
      clr();
      r.pc = 32'h0000_0010;
      send('{8'h02, 8'h00, 8'h10});
   endtask
   task automatic t_ia_stamp();
      side(4'h2);
      side(4'h1);
      repeat (3) side(4'h2);
      side(4'h8);
      side(4'h0);
      clr();
      r.trigger = 1'b1;
      r.chan = 5'h01;
      r.ts_en = 1'b1;
      r.asid_match_en = 1'b0;
      r.asid = 8'h5a;
      r.pc = 32'h0000_0f00;
      send('{8'h43, 8'h08, 8'h03, 8'h5a, 8'h80, 8'hfe});
   endtask
   task automatic t_ia_full();
      force_full = 1'b1;
      clr();
      r.chan = 5'h03;
      r.pc = 32'h1234_5678;
      send('{8'hc2, 8'h10, 8'h78, 8'h56, 8'h34, 8'h12});
      force_full = 1'b0;
   endtask
   task automatic t_oa_wide();
      slow = 1'b1;
      clr();
      r.chan = 5'h04;
      r.store_code = 3'h7;
      r.store_data = 64'h1122_3344_5566_7788;
      r.pc = 32'h1234_5698;
      send('{8'h02, 8'he1, 8'h20, 8'h44, 8'h33, 8'h22, 8'h11,
         8'h88, 8'h77, 8'h66, 8'h55});
      slow = 1'b0;
   endtask
   task automatic t_iv_byte();
      clr();
      r.chan = 5'h06;
      r.store_code = 3'h4;
      r.store_data = 64'h0000_0000_0000_00ab;
      r.payload_select_bit = 1'b1;
      r.op_addr = 32'hcafe_0010;
      r.pc = 32'h1234_5698;
      send('{8'h82, 8'h81, 8'h00, 8'h10, 8'h00, 8'hfe, 8'hca, 8'hab});
   endtask
   task automatic t_branch();
      clr();
      r.trigger = 1'b1;
      r.chan = 5'h08;
      r.branch_target_field = 32'h1234_56d8;
      r.delay_slot = 32'h1234_56da;
      r.compact_delayed = 1'b1;
      send('{8'h02, 8'h02, 8'hc0, 8'h00, 8'h02});
   endtask
   task automatic t_print();
      slow = 1'b1;
      clr();
      r.chan = 5'h09;
      r.ts_en = 1'b1;
      r.asid = 8'h5a;
      r.pc = 32'h0000_1000;
      r.print_payload = 64'h0102_0304_0506_0708;
      send('{8'h43, 8'h02, 8'h5a, 8'h00, 8'h10, 8'h00, 8'h00, 8'h08,
         8'h07, 8'h06, 8'h05, 8'h04, 8'h03, 8'h02, 8'h01});
      slow = 1'b0;
      clr();
      r.chan = 5'h02;
      r.pc = 32'h1234_56db;
      send('{8'h82, 8'h00, 8'h01});
   endtask
   task automatic t_analyzer();
      side(4'h4);
      side(4'h0);
      clr();
      r.origin_ba = 1'b1;
      r.chan = 5'h01;
      r.ba_body = 40'h05_0403_0201;
      send('{8'h4a, 8'h08, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05});
   endtask

   initial begin
      repeat (10) @(posedge clk);
      #1 rstn = 1'b1;
      t_ia_rel();
      t_ia_stamp();
      t_ia_full();
      t_oa_wide();
      t_iv_byte();
      t_branch();
      t_print();
      t_analyzer();
      final_report();
   end
endmodule
